// >>> shared/sys_clock_regs.vh
`ifndef SYS_CLOCK_REGS_VH
`define SYS_CLOCK_REGS_VH

// ----------------------------------------------------------------------
// reset configuration field widths and bus clock output count
// ----------------------------------------------------------------------
`define SYS_MULT_W 4
`define CORE_PLL_W 7
`define ENG_MULT_W 5
`define BUS_CLK_OUTS 3

// ----------------------------------------------------------------------
// system multiplier decode limits
// ----------------------------------------------------------------------
`define SYS_MULT_MIN 4'h2
`define SYS_MULT_MAX 4'h6

// ----------------------------------------------------------------------
// engine multiplier decode limits
// ----------------------------------------------------------------------
`define ENG_MULT_MIN 5'h02
`define ENG_MULT_MAX 5'h08

// ----------------------------------------------------------------------
// unit clock ratio codes (code equals divisor)
// ----------------------------------------------------------------------
`define UNIT_OFF 2'h0
`define UNIT_FULL 2'h1
`define UNIT_HALF 2'h2
`define UNIT_THIRD 2'h3

// ----------------------------------------------------------------------
// local bus divide codes
// ----------------------------------------------------------------------
`define LCL_DIV_STOP 2'h0
`define LCL_DIV_2 2'h1
`define LCL_DIV_4 2'h2
`define LCL_DIV_8 2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BUS_CLK_RESET 3'h0
`define UNIT_RESET 2'h1

`endif

// >>> design/tick_divider.v
module tick_divider #(
  parameter WIDTH = 3
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire clkEn,
  // divide control
  input wire tick,
  input wire [WIDTH-1:0] divisor,
  // result
  output reg pulse
);

  reg [WIDTH-1:0] count_reg;

  // ----------------------------------------------------------------------
  // count ticks, pulse once per divisor ticks; divisor zero stops it
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= {WIDTH{1'b0}};
      pulse <= 1'b0;
    end else if (clkEn) begin
      if (divisor == {WIDTH{1'b0}}) begin
        count_reg <= {WIDTH{1'b0}};
        pulse <= 1'b0;
      end else if (tick) begin
        if (count_reg >= divisor - {{(WIDTH-1){1'b0}}, 1'b1}) begin
          count_reg <= {WIDTH{1'b0}};
          pulse <= 1'b1;
        end else begin
          count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
          pulse <= 1'b0;
        end
      end else begin
        pulse <= 1'b0;
      end
    end
  end

endmodule // tick_divider

// >>> design/system_clock_generation_unit.v
// Overview of operation
// - primary clock from crystal, system or sync-in
// - host mode uses crystal or system clock input
// - divide select picks sync-out full or half
// - host mode drives three bus clock outputs
// - bus clocks held low after reset
// - each bus clock toggles once enabled
// - enabled bus clocks stay phase aligned
// - agent mode uses sync-in, outputs unused
// - system bus ratio: (1+divsel) times multiplier
// - multipliers come from low reset word
// - engine clock: multiply over one plus divide
// - memory clock twice bus, pair halves it
// - local bus clock via divide field
// - local clock half/quarter/eighth, internal 1x/2x
// - four units: off, full, half, third
// - system multiplier codes two..six, engine two..eight, rest reserved
`include "sys_clock_regs.vh"

module system_clock_generation_unit #(
  parameter BUS_OUTS = `BUS_CLK_OUTS
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire clkEn,
  // clock pins
  input wire crystalInput,
  input wire sysClockInput,
  input wire syncInput,
  // reset straps
  input wire hostModeSelect,
  input wire crystalSourceSelect,
  input wire inputDivideSelect,
  input wire [`SYS_MULT_W-1:0] systemMultiplierField,
  input wire [`CORE_PLL_W-1:0] processorPllField,
  input wire [`ENG_MULT_W-1:0] engineMultiplyField,
  input wire engineDivideField,
  input wire localBusModeBit,
  input wire memoryClockModeBit,
  // run-time control
  input wire [BUS_OUTS-1:0] agentClockOutputEnable,
  input wire [1:0] localClockDivideField,
  input wire [1:0] i2cClockRatio,
  input wire [1:0] sdClockRatio,
  input wire [1:0] usbClockRatio,
  input wire [1:0] dmaClockRatio,
  // clock outputs
  output reg syncOutput,
  output reg [BUS_OUTS-1:0] busClockOutput,
  output reg memoryBusClock,
  output reg memoryBusClockN,
  output reg externalLocalBusClock,
  output reg systemBusTick,
  output reg internalLocalBusTick,
  output wire [3:0] unitClockTick,
  // configuration status
  output reg hostModeActive,
  output reg [3:0] csbToSyncRatio,
  output reg systemMultiplierReserved,
  output reg [`ENG_MULT_W-1:0] engineNumerator,
  output reg [1:0] engineDenominator,
  output reg engineMultiplierReserved,
  output reg [`CORE_PLL_W-1:0] processorPllSetting,
  output reg memoryClockMode
);

  // ----------------------------------------------------------------------
  // pin synchronisers: three stages, a change counts when two and three agree
  // ----------------------------------------------------------------------
  reg [2:0] xtalSync_reg;
  reg [2:0] sysSync_reg;
  reg [2:0] syncInSync_reg;
  reg xtalLevel_reg;
  reg sysLevel_reg;
  reg syncInLevel_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      xtalSync_reg <= 3'h0;
      sysSync_reg <= 3'h0;
      syncInSync_reg <= 3'h0;
      xtalLevel_reg <= 1'b0;
      sysLevel_reg <= 1'b0;
      syncInLevel_reg <= 1'b0;
    end else if (clkEn) begin
      xtalSync_reg <= {xtalSync_reg[1:0], crystalInput};
      sysSync_reg <= {sysSync_reg[1:0], sysClockInput};
      syncInSync_reg <= {syncInSync_reg[1:0], syncInput};
      if (xtalSync_reg[1] == xtalSync_reg[2]) begin
        xtalLevel_reg <= xtalSync_reg[2];
      end
      if (sysSync_reg[1] == sysSync_reg[2]) begin
        sysLevel_reg <= sysSync_reg[2];
      end
      if (syncInSync_reg[1] == syncInSync_reg[2]) begin
        syncInLevel_reg <= syncInSync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // straps caught on the first enabled edge after reset release
  // ----------------------------------------------------------------------
  reg strapTaken_reg;
  reg hostMode_reg;
  reg xtalSel_reg;
  reg divSel_reg;
  reg [`SYS_MULT_W-1:0] sysMult_reg;
  reg [`ENG_MULT_W-1:0] engMult_reg;
  reg engDiv_reg;
  reg lbMode_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      strapTaken_reg <= 1'b0;
      hostMode_reg <= 1'b0;
      xtalSel_reg <= 1'b0;
      divSel_reg <= 1'b0;
      sysMult_reg <= {`SYS_MULT_W{1'b0}};
      engMult_reg <= {`ENG_MULT_W{1'b0}};
      engDiv_reg <= 1'b0;
      lbMode_reg <= 1'b0;
      processorPllSetting <= {`CORE_PLL_W{1'b0}};
      memoryClockMode <= 1'b0;
    end else if (clkEn && !strapTaken_reg) begin
      // straps are sampled once; later pin changes are ignored
      strapTaken_reg <= 1'b1;
      hostMode_reg <= hostModeSelect;
      xtalSel_reg <= crystalSourceSelect;
      divSel_reg <= inputDivideSelect;
      sysMult_reg <= systemMultiplierField;
      engMult_reg <= engineMultiplyField;
      engDiv_reg <= engineDivideField;
      lbMode_reg <= localBusModeBit;
      processorPllSetting <= processorPllField;
      memoryClockMode <= memoryClockModeBit;
    end
  end

  // ----------------------------------------------------------------------
  // primary clock selection and sync-out generation
  // ----------------------------------------------------------------------
  reg primaryLevel;
  reg primaryPrev_reg;
  reg halfClock_reg;
  reg srcNext;
  reg [BUS_OUTS-1:0] gateEnable_reg;
  wire primaryRise;

  always @* begin
    if (hostMode_reg) begin
      primaryLevel = xtalSel_reg ? xtalLevel_reg : sysLevel_reg;
    end else begin
      primaryLevel = syncInLevel_reg;
    end
  end

  assign primaryRise = primaryLevel & ~primaryPrev_reg;

  always @* begin
    if (!hostMode_reg || !strapTaken_reg) begin
      srcNext = 1'b0;
    end else if (divSel_reg) begin
      srcNext = primaryRise ? ~halfClock_reg : halfClock_reg;
    end else begin
      srcNext = primaryLevel;
    end
  end

  // ----------------------------------------------------------------------
  // bus clock outputs: one shared source, enables move only in low phase
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      primaryPrev_reg <= 1'b0;
      halfClock_reg <= 1'b0;
      syncOutput <= 1'b0;
      gateEnable_reg <= `BUS_CLK_RESET;
      busClockOutput <= {BUS_OUTS{1'b0}};
    end else if (clkEn) begin
      primaryPrev_reg <= primaryLevel;
      if (primaryRise) begin
        halfClock_reg <= ~halfClock_reg;
      end
      syncOutput <= srcNext;
      if (!srcNext) begin
        // a change taken here starts or ends on a whole period
        gateEnable_reg <= agentClockOutputEnable;
      end
      // every output samples the same source bit, so edges coincide
      busClockOutput <= {BUS_OUTS{srcNext}} & (srcNext ? gateEnable_reg
        : {BUS_OUTS{1'b0}});
    end
  end

  // ----------------------------------------------------------------------
  // derived domains: clk stands for the memory controller clock
  // ----------------------------------------------------------------------
  reg [1:0] lclHalf;
  wire lclPulse;

  always @(posedge clk) begin
    if (!rst_n) begin
      systemBusTick <= 1'b0;
      memoryBusClock <= 1'b0;
      memoryBusClockN <= 1'b1;
      internalLocalBusTick <= 1'b0;
      externalLocalBusClock <= 1'b0;
    end else if (clkEn) begin
      // system bus runs at half the memory controller rate
      systemBusTick <= ~systemBusTick;
      // pair divides the controller clock by two; data moves every clk
      memoryBusClock <= ~memoryBusClock;
      memoryBusClockN <= memoryBusClock;
      // internal local bus clock: 1x or 2x the system bus
      internalLocalBusTick <= lbMode_reg | ~systemBusTick;
      if (localClockDivideField == `LCL_DIV_STOP) begin
        externalLocalBusClock <= 1'b0;
      end else if (lclPulse) begin
        externalLocalBusClock <= ~externalLocalBusClock;
      end
    end
  end

  // half period of the external clock in internal ticks: 1, 2 or 4
  always @* begin
    case (localClockDivideField)
      `LCL_DIV_2: lclHalf = 2'h1;
      `LCL_DIV_4: lclHalf = 2'h2;
      `LCL_DIV_8: lclHalf = 2'h3;
      default: lclHalf = 2'h0;
    endcase
  end

  tick_divider #(
    .WIDTH(3)
  ) localDivider (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .tick(internalLocalBusTick),
    .divisor(lclHalf == 2'h0 ? 3'h0 : (3'h1 << (lclHalf - 2'h1))),
    .pulse(lclPulse)
  );

  // ----------------------------------------------------------------------
  // configurable units; software must set a ratio before using a unit
  // ----------------------------------------------------------------------
  wire [7:0] unitRatios;

  assign unitRatios = {dmaClockRatio, usbClockRatio, sdClockRatio, i2cClockRatio};

  genvar u;
  generate
    for (u = 0; u < 4; u = u + 1) begin : unitDiv
      tick_divider #(
        .WIDTH(2)
      ) unitDivider (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .tick(systemBusTick),
        .divisor(unitRatios[2*u+1:2*u]),
        .pulse(unitClockTick[u])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // ratio decode from the captured reset word
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      hostModeActive <= 1'b0;
      csbToSyncRatio <= 4'h0;
      systemMultiplierReserved <= 1'b0;
      engineNumerator <= {`ENG_MULT_W{1'b0}};
      engineDenominator <= 2'h1;
      engineMultiplierReserved <= 1'b0;
    end else if (clkEn) begin
      hostModeActive <= hostMode_reg;
      if (sysMult_reg >= `SYS_MULT_MIN && sysMult_reg <= `SYS_MULT_MAX) begin
        // reserved codes report a zero ratio
        csbToSyncRatio <= divSel_reg ? {sysMult_reg[2:0], 1'b0}
          : sysMult_reg;
        systemMultiplierReserved <= 1'b0;
      end else begin
        csbToSyncRatio <= 4'h0;
        systemMultiplierReserved <= strapTaken_reg;
      end
      if (engMult_reg >= `ENG_MULT_MIN && engMult_reg <= `ENG_MULT_MAX) begin
        engineNumerator <= engMult_reg;
        engineMultiplierReserved <= 1'b0;
      end else begin
        engineNumerator <= {`ENG_MULT_W{1'b0}};
        engineMultiplierReserved <= strapTaken_reg;
      end
      engineDenominator <= {1'b0, 1'b1} + {1'b0, engDiv_reg};
    end
  end

  // frequency ceilings are the board's job; nothing here limits them

endmodule // system_clock_generation_unit

// >>> verification/clock_unit_properties.sv
`include "sys_clock_regs.vh"

module clock_unit_properties #(
  parameter BUS_OUTS = 3
) (
  // clock, reset, straps and the i2c unit ratio
  input wire clk,
  input wire rst_n,
  input wire clkEn,
  input wire inputDivideSelect,
  input wire [`SYS_MULT_W-1:0] systemMultiplierField,
  input wire engineDivideField,
  input wire [1:0] i2cClockRatio,
  // outputs watched
  input wire syncOutput,
  input wire [BUS_OUTS-1:0] busClockOutput,
  input wire memoryBusClock,
  input wire memoryBusClockN,
  input wire systemBusTick,
  input wire [3:0] unitClockTick,
  input wire hostModeActive,
  input wire [3:0] csbToSyncRatio,
  input wire systemMultiplierReserved,
  input wire [`ENG_MULT_W-1:0] engineNumerator,
  input wire [1:0] engineDenominator
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_reset_low: assert property (disable iff (1'b0) !rst_n |=> busClockOutput == 0)
    else $error("bus clock not low in reset");
  a_bus_aligned: assert property ($rose(busClockOutput[0]) |->
    !$past(busClockOutput[1]) && !$past(busClockOutput[2]))
    else $error("bus clocks out of phase");
  a_gate_whole: assert property (busClockOutput != $past(busClockOutput) |->
    syncOutput != $past(syncOutput))
    else $error("bus clock edge away from source edge");
  a_agent_quiet: assert property (!hostModeActive |-> busClockOutput == 0 && !syncOutput)
    else $error("clock output active in agent mode");
  a_mem_pair: assert property (memoryBusClock != memoryBusClockN)
    else $error("memory clock pair not complementary");
  // the release edge still resets the pair, so start counting one edge later
  a_mem_toggle: assert property (rst_n && clkEn |=> memoryBusClock != $past(memoryBusClock))
    else $error("memory clock missed a toggle");
  a_tick_half: assert property ($rose(systemBusTick) && clkEn |=> !systemBusTick)
    else $error("system tick not half rate");
  a_ratio_decode: assert property (csbToSyncRatio != 4'h0 |->
    csbToSyncRatio == systemMultiplierField * ({3'h0, inputDivideSelect} + 4'h1))
    else $error("bus to sync ratio wrong");
  a_sysmul_reserved: assert property (systemMultiplierReserved |-> csbToSyncRatio == 4'h0 &&
    (systemMultiplierField < 4'h2 || systemMultiplierField > 4'h6))
    else $error("reserved multiplier flag wrong");
  a_engine_den: assert property (engineNumerator != 0 |->
    engineDenominator == {1'b0, engineDivideField} + 2'h1)
    else $error("engine denominator wrong");
  a_unit_off: assert property ((i2cClockRatio == 2'h0) [*4] |-> !unitClockTick[0])
    else $error("stopped unit still ticking");
endmodule // clock_unit_properties

bind system_clock_generation_unit clock_unit_properties #(.BUS_OUTS(BUS_OUTS)) props (
  .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .inputDivideSelect(inputDivideSelect),
  .systemMultiplierField(systemMultiplierField), .engineDivideField(engineDivideField),
  .i2cClockRatio(i2cClockRatio), .syncOutput(syncOutput), .busClockOutput(busClockOutput),
  .memoryBusClock(memoryBusClock), .memoryBusClockN(memoryBusClockN),
  .systemBusTick(systemBusTick), .unitClockTick(unitClockTick),
  .hostModeActive(hostModeActive), .csbToSyncRatio(csbToSyncRatio),
  .systemMultiplierReserved(systemMultiplierReserved), .engineNumerator(engineNumerator),
  .engineDenominator(engineDenominator));

// >>> verification/board_clock_model.sv
module board_clock_model #(
  // input periods keep every derived clock under its ceiling
  parameter SYS_HALF = 6,
  parameter XTAL_HALF = 10,
  parameter SYNC_HALF = 8
) (
  // clock and mode
  input wire clk,
  input wire hostMode,
  input wire syncOutput,
  // board clocks
  output wire crystalInput,
  output wire sysClockInput,
  output wire syncInput
);
  timeunit 1ns;
  timeprecision 1ps;
  int sysCnt = 0;
  int xtalCnt = 0;
  int syncCnt = 0;
  logic sysClk = 1'b0;
  logic xtalClk = 1'b0;
  logic agentSync = 1'b0;

  always @(posedge clk) begin
    sysCnt <= (sysCnt == SYS_HALF - 1) ? 0 : sysCnt + 1;
    xtalCnt <= (xtalCnt == XTAL_HALF - 1) ? 0 : xtalCnt + 1;
    syncCnt <= (syncCnt == SYNC_HALF - 1) ? 0 : syncCnt + 1;
    if (sysCnt == SYS_HALF - 1) sysClk <= ~sysClk;
    if (xtalCnt == XTAL_HALF - 1) xtalClk <= ~xtalClk;
    if (syncCnt == SYNC_HALF - 1) agentSync <= ~agentSync;
  end

  assign crystalInput = xtalClk;
  // system input grounded on an agent board
  assign sysClockInput = hostMode ? sysClk : 1'b0;
  // host boards loop sync-out straight back to sync-in
  assign syncInput = hostMode ? syncOutput : agentSync;
endmodule // board_clock_model

// >>> verification/system_clock_generation_unit_test.sv
module system_clock_generation_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, clkEn = 1, hostMode = 1, xtalSel = 0, divSel = 0;
  logic lbMode = 0, memMode = 0, engDiv = 0;
  logic [3:0] system_multiplier_field = 4'h4;
  logic [6:0] pll = 7'h05;
  logic [4:0] engMul = 5'h04;
  logic [2:0] busEn = 3'h0;
  logic [1:0] lclDiv = 2'h1;
  logic [1:0] unitR [4] = '{2'h1, 2'h1, 2'h1, 2'h1};
  wire xtal, sysIn, syncIn, syncOut, memClk, memClkN, extLcl, sysTick, lclTick;
  wire hostAct, spRes, enRes, memMd;
  wire [2:0] busClk;
  wire [3:0] unitTick, ratio;
  wire [4:0] engNum;
  wire [1:0] engDen;
  wire [6:0] pllSet;
  int failures = 0, comparisons = 0, cycles = 0, q, e;
  int cnt [9] = '{default: 0};
  int got [9];
  logic [31:0] seed = 32'hccee5036, r;
  logic [8:0] watch, watchPrev = '0;

  board_clock_model partner (.clk(clk), .hostMode(hostMode), .syncOutput(syncOut),
    .crystalInput(xtal), .sysClockInput(sysIn), .syncInput(syncIn));
  system_clock_generation_unit dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .crystalInput(xtal), .sysClockInput(sysIn), .syncInput(syncIn),
    .hostModeSelect(hostMode), .crystalSourceSelect(xtalSel), .inputDivideSelect(divSel),
    .systemMultiplierField(system_multiplier_field), .processorPllField(pll), .engineMultiplyField(engMul),
    .engineDivideField(engDiv), .localBusModeBit(lbMode), .memoryClockModeBit(memMode),
    .agentClockOutputEnable(busEn), .localClockDivideField(lclDiv),
    .i2cClockRatio(unitR[0]), .sdClockRatio(unitR[1]), .usbClockRatio(unitR[2]),
    .dmaClockRatio(unitR[3]), .syncOutput(syncOut), .busClockOutput(busClk),
    .memoryBusClock(memClk), .memoryBusClockN(memClkN), .externalLocalBusClock(extLcl),
    .systemBusTick(sysTick), .internalLocalBusTick(lclTick), .unitClockTick(unitTick),
    .hostModeActive(hostAct), .csbToSyncRatio(ratio), .systemMultiplierReserved(spRes),
    .engineNumerator(engNum), .engineDenominator(engDen),
    .engineMultiplierReserved(enRes), .processorPllSetting(pllSet),
    .memoryClockMode(memMd));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // rising-edge counters on the watched clocks
  // ----------------------------------------------------------------------
  assign watch = {extLcl, unitTick, syncOut, busClk};
  always @(posedge clk) begin
    cycles <= cycles + 1;
    watchPrev <= watch;
    for (int i = 0; i < 9; i++) if (watch[i] && !watchPrev[i]) cnt[i] <= cnt[i] + 1;
    if (cycles == 12000) begin
      failures++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] expRatio(logic [3:0] m, logic d);
    if (m < 4'h2 || m > 4'h6) return 4'h0;
    return d ? m << 1 : m;
  endfunction
  // counts may gain or lose one edge to the window phase
  function automatic logic near(int seen, int exp);
    return seen >= exp - 1 && seen <= exp + 1;
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic restart();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic measure(int n);
    int base [9];
    base = cnt;
    repeat (n) @(posedge clk);
    foreach (got[i]) got[i] = cnt[i] - base[i];
  endtask
  task automatic results();
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    restart();
    measure(240);
    check(got[0] + got[1] + got[2], 0);
    check(hostAct, 1'b1);
    check(near(got[3], 20), 1);
    for (int k = 0; k < 5; k++) begin
      r = rnd();
      busEn <= (k == 0) ? 3'h5 : (k == 1) ? 3'h2 : (k == 2) ? 3'h7 : r[2:0];
      repeat (24) @(posedge clk);
      measure(240);
      for (int i = 0; i < 3; i++) check(busEn[i] ? near(got[i], 20) : got[i] == 0, 1);
    end
    // a low enable must freeze the bus clocks, sync-out and external local bus clock
    clkEn <= 1'b0;
    repeat (2) @(posedge clk);
    measure(60);
    check(got[0] + got[1] + got[2] + got[3] + got[8], 0);
    clkEn <= 1'b1;
    divSel <= 1'b1;
    restart();
    measure(240);
    check(near(got[3], 10), 1);
    divSel <= 1'b0;
    xtalSel <= 1'b1;
    restart();
    measure(240);
    check(near(got[3], 12), 1);
    hostMode <= 1'b0;
    restart();
    measure(240);
    check(got[0] + got[1] + got[2] + got[3], 0);
    for (int m = 0; m < 16; m++) begin
      r = rnd();
      system_multiplier_field <= m[3:0];
      divSel <= r[0];
      engDiv <= r[1];
      engMul <= {m[3:0], r[2]};
      pll <= r[9:3];
      memMode <= r[10];
      restart();
      check(ratio, expRatio(m[3:0], divSel));
      check(spRes, m < 2 || m > 6);
      e = engMul;
      check(engNum, (e >= 2 && e <= 8) ? engMul : 5'h00);
      check(enRes, e < 2 || e > 8);
      check(engDen, {1'b0, engDiv} + 2'h1);
      check(pllSet, pll);
      check(memMd, memMode);
      check(hostAct, hostMode);
    end
    hostMode <= 1'b1;
    xtalSel <= 1'b0;
    restart();
    for (int k = 0; k < 4; k++) begin
      for (int u = 0; u < 4; u++) unitR[u] <= 2'(k + u);
      repeat (12) @(posedge clk);
      measure(240);
      for (int u = 0; u < 4; u++) begin
        q = (k + u) % 4;
        check(near(got[4 + u], q == 0 ? 0 : 120 / q), 1);
      end
    end
    for (int b = 0; b < 2; b++) begin
      lbMode <= b[0];
      restart();
      for (int c = 0; c < 4; c++) begin
        lclDiv <= c[1:0];
        repeat (20) @(posedge clk);
        measure(240);
        e = (c == 0) ? 0 : 240 / ((2 << (c - 1)) * (b ? 1 : 2));
        check(near(got[8], e), 1);
      end
    end
    results();
  end
endmodule // system_clock_generation_unit_test
